// file: rtl/nvm_control.sv
`default_nettype none
// Behaviour
// - status bit 0 reads 1 while a save or load is running, read only
// - with pin-select bit 7 set, busy flag also drives the status pin
// - error bit 0 reads 1 after bad data in a load, read only
// - with select pin low, writing reload bit starts a load; bit self-clears
// - write-enable bit 0, default 0, blocks every save into storage
// - save bit starts copy to storage, reads 1 until copy done
// - command bit 7 clear: length plus one bytes, then address MSB first
// - command bit 7 set: commit opcode or end marker stopping transfer
// - update bit pulses commit on next edge and self-clears
module nvm_control (
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic        regWrEn,
  input  wire logic        regRdEn,
  input  wire logic [11:0] regAddr,
  input  wire logic [7:0]  regWrData,
  output logic      [7:0]  regRdData,
  input  wire logic        nvmSelPin,
  output logic             statusPin,
  output logic      [11:0] bufAddr,
  input  wire logic [7:0]  bufRdData,
  output logic             bufWrEn,
  output logic      [7:0]  bufWrData,
  output logic             activeUpdate
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  nvm_pkg::walk_state_t state_q;
  logic        saving_q;
  logic [5:0]  segIdx_q;
  logic [5:0]  nvmIdx_q;
  logic [6:0]  count_q;
  logic [11:0] dataAddr_q;
  logic        wrEnable_q;
  logic        pinSel_q;
  logic        error_q;
  logic        activeUpdate_q;
  logic [7:0]  regRdData_q;
  logic [7:0]  nvmRdData;
  logic [7:0]  srcByte;
  logic        busy;
  logic        saveReq;
  logic        loadReq;
  logic        lastByte;
  logic        isEnd;
  logic        isOpUpd;
  logic        badOp;

  function automatic logic hit(input logic [11:0] addr, input logic [11:0] ofs);
    hit = (addr == ofs);
  endfunction : hit

  // ------------------------------------------------------------
  // request decode
  // ------------------------------------------------------------
  assign busy     = (state_q != nvm_pkg::ST_IDLE);
  assign saveReq  = regWrEn && hit(regAddr, nvm_pkg::OFS_SAVE) && regWrData[nvm_pkg::BIT_SAVE]
                    && wrEnable_q && !busy;
  assign loadReq  = regWrEn && hit(regAddr, nvm_pkg::OFS_RELOAD) && regWrData[nvm_pkg::BIT_RELOAD]
                    && !nvmSelPin && !busy;
  assign srcByte  = saving_q ? bufRdData : nvmRdData;
  assign lastByte = (nvmIdx_q == nvm_pkg::NVM_LAST);
  assign isEnd    = (srcByte == nvm_pkg::OP_END);
  assign isOpUpd  = (srcByte == nvm_pkg::OP_UPDATE);
  assign badOp    = srcByte[nvm_pkg::BIT_OPCODE] && !isEnd && !isOpUpd;

  // ------------------------------------------------------------
  // command list walker
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= nvm_pkg::ST_IDLE;
    end else begin
      unique case (state_q)
        nvm_pkg::ST_IDLE: begin
          if (saveReq || loadReq) begin
            state_q <= nvm_pkg::ST_CMD;
          end
        end
        nvm_pkg::ST_CMD: begin
          if (isEnd || badOp || lastByte) begin
            state_q <= nvm_pkg::ST_IDLE;
          end else if (!srcByte[nvm_pkg::BIT_OPCODE]) begin
            state_q <= nvm_pkg::ST_AHI;
          end
        end
        nvm_pkg::ST_AHI: begin
          state_q <= lastByte ? nvm_pkg::ST_IDLE : nvm_pkg::ST_ALO;
        end
        nvm_pkg::ST_ALO: begin
          state_q <= lastByte ? nvm_pkg::ST_IDLE : nvm_pkg::ST_DATA;
        end
        nvm_pkg::ST_DATA: begin
          if (lastByte) begin
            state_q <= nvm_pkg::ST_IDLE;
          end else if (count_q == 7'h00) begin
            state_q <= nvm_pkg::ST_CMD;
          end
        end
        default: state_q <= nvm_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      saving_q   <= 1'b0;
      segIdx_q   <= 6'h00;
      nvmIdx_q   <= 6'h00;
      count_q    <= 7'h00;
      dataAddr_q <= 12'h000;
    end else if (!busy) begin
      saving_q <= saveReq;
      segIdx_q <= 6'h00;
      nvmIdx_q <= 6'h00;
    end else begin
      nvmIdx_q <= nvmIdx_q + 6'h01;
      if (state_q != nvm_pkg::ST_DATA) begin
        segIdx_q <= segIdx_q + 6'h01;
      end
      unique case (state_q)
        nvm_pkg::ST_CMD:  count_q <= srcByte[6:0];
        nvm_pkg::ST_AHI:  dataAddr_q[11:8] <= srcByte[3:0];
        nvm_pkg::ST_ALO:  dataAddr_q[7:0] <= srcByte;
        nvm_pkg::ST_DATA: begin
          dataAddr_q <= dataAddr_q + 12'h001;
          count_q    <= count_q - 7'h01;
        end
        default: count_q <= count_q;
      endcase
    end
  end

  // ------------------------------------------------------------
  // storage and buffer side
  // ------------------------------------------------------------
  nvm_array u_array (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .wrEn     (saving_q && busy),
    .wrIdx    (nvmIdx_q),
    .wrData   (bufRdData),
    .rdIdx    (nvmIdx_q),
    .rdData   (nvmRdData)
  );

  assign bufAddr   = (state_q == nvm_pkg::ST_DATA) ? dataAddr_q : nvm_pkg::SEG_BASE + {6'h00, segIdx_q};
  assign bufWrEn   = !saving_q && (state_q == nvm_pkg::ST_DATA);
  assign bufWrData = nvmRdData;

  // ------------------------------------------------------------
  // control bits and flags
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wrEnable_q <= nvm_pkg::WR_EN_RST;
      pinSel_q   <= nvm_pkg::PIN_SEL_RST;
    end else if (regWrEn) begin
      if (hit(regAddr, nvm_pkg::OFS_RELOAD)) begin
        wrEnable_q <= regWrData[nvm_pkg::BIT_WR_EN];
      end
      if (hit(regAddr, nvm_pkg::OFS_PIN_SEL)) begin
        pinSel_q <= regWrData[nvm_pkg::BIT_PIN_SEL];
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      error_q <= 1'b0;
    end else if (loadReq) begin
      error_q <= 1'b0;
    end else if (busy && !saving_q && (badOp && state_q == nvm_pkg::ST_CMD || lastByte && !isEnd)) begin
      error_q <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      activeUpdate_q <= 1'b0;
    end else begin
      activeUpdate_q <= (regWrEn && hit(regAddr, nvm_pkg::OFS_UPDATE) && regWrData[nvm_pkg::BIT_UPDATE])
                        || (busy && !saving_q && state_q == nvm_pkg::ST_CMD && isOpUpd);
    end
  end

  assign activeUpdate = activeUpdate_q;
  assign statusPin    = pinSel_q && busy;

  // ------------------------------------------------------------
  // register read
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      regRdData_q <= 8'h00;
    end else if (regRdEn) begin
      regRdData_q <= 8'h00;
      if (hit(regAddr, nvm_pkg::OFS_STATUS)) begin
        regRdData_q[nvm_pkg::BIT_BUSY] <= busy;
      end
      if (hit(regAddr, nvm_pkg::OFS_ERROR)) begin
        regRdData_q[nvm_pkg::BIT_ERR] <= error_q;
      end
      if (hit(regAddr, nvm_pkg::OFS_RELOAD)) begin
        regRdData_q[nvm_pkg::BIT_WR_EN]  <= wrEnable_q;
        regRdData_q[nvm_pkg::BIT_RELOAD] <= busy && !saving_q;
      end
      if (hit(regAddr, nvm_pkg::OFS_SAVE)) begin
        regRdData_q[nvm_pkg::BIT_SAVE] <= busy && saving_q;
      end
      if (hit(regAddr, nvm_pkg::OFS_PIN_SEL)) begin
        regRdData_q[nvm_pkg::BIT_PIN_SEL] <= pinSel_q;
      end
    end
  end

  assign regRdData = regRdData_q;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  sequence seq_header;
    state_q == nvm_pkg::ST_AHI ##1 state_q == nvm_pkg::ST_ALO ##1 state_q == nvm_pkg::ST_DATA;
  endsequence

  sequence seq_upd_pulse;
    activeUpdate ##1 !activeUpdate;
  endsequence

  a_status_read: assert property (regRdEn && hit(regAddr, nvm_pkg::OFS_STATUS)
                                  |=> regRdData[0] == $past(busy))
    else $error("status bit does not follow busy");
  a_status_pin: assert property ($rose(busy) && pinSel_q |-> statusPin ##0 busy[*1])
    else $error("status pin not driven at transfer start");
  a_error_read: assert property (regRdEn && hit(regAddr, nvm_pkg::OFS_ERROR)
                                 |=> regRdData == {7'h00, $past(error_q)})
    else $error("error register mismatch");
  a_reload_gate: assert property (regWrEn && hit(regAddr, nvm_pkg::OFS_RELOAD) && regWrData[1] && nvmSelPin
                                  && !busy |=> !busy)
    else $error("reload started with select pin high");
  a_protect_block: assert property (regWrEn && hit(regAddr, nvm_pkg::OFS_SAVE) && !wrEnable_q && !busy
                                    |=> !busy ##1 !u_array.wrEn)
    else $error("save ran while protected");
  a_save_held: assert property (saveReq |=> busy && saving_q ##1 saving_q)
    else $error("save did not start");
  a_cmd_length: assert property (state_q == nvm_pkg::ST_CMD && !srcByte[7] && !lastByte && nvmIdx_q < 6'h3C
                                 |=> seq_header ##0 count_q == $past(srcByte[6:0], 3))
    else $error("data command header walk wrong");
  a_opcode_end: assert property (state_q == nvm_pkg::ST_CMD && isEnd |=> !busy)
    else $error("end marker did not stop transfer");
  a_update_pulse: assert property (regWrEn && hit(regAddr, nvm_pkg::OFS_UPDATE) && regWrData[0] && !busy
                                   ##1 !regWrEn |-> seq_upd_pulse)
    else $error("update pulse wrong");
  a_unused_zero: assert property (regRdEn && !hit(regAddr, nvm_pkg::OFS_PIN_SEL)
                                  |=> regRdData[7:2] == 6'h00)
    else $error("unused bits not zero");
endmodule : nvm_control
`default_nettype wire

// file: rtl/nvm_pkg.sv
`default_nettype none
package nvm_pkg;
  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [11:0] OFS_STATUS   = 12'hB00;
  localparam logic [11:0] OFS_ERROR    = 12'hB01;
  localparam logic [11:0] OFS_RELOAD   = 12'hB02;
  localparam logic [11:0] OFS_SAVE     = 12'hB03;
  localparam logic [11:0] OFS_PIN_SEL  = 12'h01D;
  localparam logic [11:0] OFS_UPDATE   = 12'h232;
  localparam logic [11:0] SEG_BASE     = 12'hA00;
  // ------------------------------------------------------------
  // field positions and reset values
  // ------------------------------------------------------------
  localparam int          BIT_BUSY     = 0;
  localparam int          BIT_ERR      = 0;
  localparam int          BIT_WR_EN    = 0;
  localparam int          BIT_RELOAD   = 1;
  localparam int          BIT_SAVE     = 0;
  localparam int          BIT_PIN_SEL  = 7;
  localparam int          BIT_UPDATE   = 0;
  localparam int          BIT_OPCODE   = 7;
  localparam logic        WR_EN_RST    = 1'b0;
  localparam logic        PIN_SEL_RST  = 1'b0;
  // ------------------------------------------------------------
  // command list and storage
  // ------------------------------------------------------------
  localparam logic [7:0]  OP_UPDATE    = 8'hA0;
  localparam logic [7:0]  OP_END       = 8'hFF;
  localparam int          NVM_DEPTH    = 64;
  localparam int          NVM_IDX_W    = 6;
  localparam logic [5:0]  NVM_LAST     = 6'h3F;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_CMD  = 5'b00010,
    ST_AHI  = 5'b00100,
    ST_ALO  = 5'b01000,
    ST_DATA = 5'b10000
  } walk_state_t;
endpackage : nvm_pkg
`default_nettype wire

// file: rtl/nvm_array.sv
`default_nettype none
module nvm_array (
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  input  wire logic       wrEn,
  input  wire logic [5:0] wrIdx,
  input  wire logic [7:0] wrData,
  input  wire logic [5:0] rdIdx,
  output logic      [7:0] rdData
);
  // ------------------------------------------------------------
  // byte storage, erased state is end marker
  // ------------------------------------------------------------
  logic [7:0] mem_q [nvm_pkg::NVM_DEPTH];

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < nvm_pkg::NVM_DEPTH; i++) begin
        mem_q[i] <= nvm_pkg::OP_END;
      end
    end else if (wrEn) begin
      mem_q[wrIdx] <= wrData;
    end
  end

  assign rdData = mem_q[rdIdx];
endmodule : nvm_array
`default_nettype wire

// file: dv/nvm_buf_model.sv
`default_nettype none
module nvm_buf_model (
  input  wire logic        core_clk,
  input  wire logic [11:0] bufAddr,
  output logic      [7:0]  bufRdData,
  input  wire logic        bufWrEn,
  input  wire logic [7:0]  bufWrData,
  input  wire logic        activeUpdate,
  output int               updCount
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // buffer bank and commit counter
  // ----------------------------------------
  logic [7:0] mem [0:4095];
  int         cnt = 0;
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
  end
  assign bufRdData = mem[bufAddr];
  assign updCount  = cnt;
  always @(posedge core_clk) begin
    if (bufWrEn) mem[bufAddr] <= bufWrData;
    if (activeUpdate) cnt <= cnt + 1;
  end
endmodule : nvm_buf_model
`default_nettype wire

// file: dv/config_eeprom_control_tb.sv
`default_nettype none
module config_eeprom_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        regWrEn = 1'b0;
  logic        regRdEn = 1'b0;
  logic [11:0] regAddr = 12'h000;
  logic [7:0]  regWrData = 8'h00;
  logic        nvmSelPin = 1'b0;
  logic [7:0]  regRdData;
  logic        statusPin;
  logic [11:0] bufAddr;
  logic [7:0]  bufRdData;
  logic        bufWrEn;
  logic [7:0]  bufWrData;
  logic        activeUpdate;
  int          updCount;
  int          nMismatch = 0;
  int          checkCount = 0;
  always #20 core_clk = ~core_clk;
  nvm_control dut (.core_clk(core_clk), .reset_n(reset_n), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData), .nvmSelPin(nvmSelPin),
    .statusPin(statusPin), .bufAddr(bufAddr), .bufRdData(bufRdData), .bufWrEn(bufWrEn),
    .bufWrData(bufWrData), .activeUpdate(activeUpdate));
  nvm_buf_model bfm (.core_clk(core_clk), .bufAddr(bufAddr), .bufRdData(bufRdData),
    .bufWrEn(bufWrEn), .bufWrData(bufWrData), .activeUpdate(activeUpdate), .updCount(updCount));
  // ----------------------------------------
  // bus and check tasks
  // ----------------------------------------
  task automatic giveVerdict();
    $display("mismatches %0d checks %0d", nMismatch, checkCount);
    if (nMismatch == 0 && checkCount > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : giveVerdict
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checkCount++;
    if (got !== exp) begin
      nMismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1;
    regWrEn = 1'b1;
    regAddr = a;
    regWrData = d;
    @(posedge core_clk);
    #1;
    regWrEn = 1'b0;
  endtask : wr
  task automatic chk(input logic [11:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    #1;
    regRdEn = 1'b1;
    regAddr = a;
    @(posedge core_clk);
    #1;
    regRdEn = 1'b0;
    cmp(regRdData, exp);
  endtask : chk
  task automatic waitIdle();
    int n;
    n = 0;
    while (statusPin !== 1'b0 && n < 400) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (n == 400) begin
      nMismatch++;
      giveVerdict();
    end
    repeat (260) @(posedge core_clk);
    #1;
  endtask : waitIdle
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic tReset();
    wr(nvm_pkg::OFS_STATUS, 8'hFF);
    chk(nvm_pkg::OFS_STATUS, 8'h00);
    chk(nvm_pkg::OFS_ERROR, 8'h00);
    chk(nvm_pkg::OFS_RELOAD, 8'h00);
    chk(nvm_pkg::OFS_SAVE, 8'h00);
    chk(12'hB04, 8'h00);
  endtask : tReset
  task automatic tUpdate();
    int c;
    c = updCount;
    wr(nvm_pkg::OFS_UPDATE, 8'h01);
    cmp({7'h00, activeUpdate}, 8'h01);
    @(posedge core_clk);
    #1;
    cmp({7'h00, activeUpdate}, 8'h00);
    cmp(8'(updCount - c), 8'h01);
    chk(nvm_pkg::OFS_UPDATE, 8'h00);
  endtask : tUpdate
  task automatic tSave();
    bfm.mem[12'hA00] = 8'h01;
    bfm.mem[12'hA01] = 8'h00;
    bfm.mem[12'hA02] = 8'h10;
    bfm.mem[12'hA03] = nvm_pkg::OP_UPDATE;
    bfm.mem[12'hA04] = nvm_pkg::OP_END;
    bfm.mem[12'h010] = 8'h5A;
    bfm.mem[12'h011] = 8'hC3;
    wr(nvm_pkg::OFS_PIN_SEL, 8'h80);
    chk(nvm_pkg::OFS_PIN_SEL, 8'h80);
    wr(nvm_pkg::OFS_SAVE, 8'h01);
    chk(nvm_pkg::OFS_STATUS, 8'h00);
    wr(nvm_pkg::OFS_RELOAD, 8'h01);
    chk(nvm_pkg::OFS_RELOAD, 8'h01);
    wr(nvm_pkg::OFS_SAVE, 8'hFF);
    cmp({7'h00, statusPin}, 8'h01);
    chk(nvm_pkg::OFS_SAVE, 8'h01);
    chk(nvm_pkg::OFS_STATUS, 8'h01);
    waitIdle();
    chk(nvm_pkg::OFS_SAVE, 8'h00);
    chk(nvm_pkg::OFS_STATUS, 8'h00);
  endtask : tSave
  task automatic tLoad();
    int c;
    bfm.mem[12'h010] = 8'h00;
    bfm.mem[12'h011] = 8'h00;
    nvmSelPin = 1'b1;
    wr(nvm_pkg::OFS_RELOAD, 8'h03);
    chk(nvm_pkg::OFS_STATUS, 8'h00);
    nvmSelPin = 1'b0;
    c = updCount;
    wr(nvm_pkg::OFS_RELOAD, 8'h03);
    chk(nvm_pkg::OFS_RELOAD, 8'h03);
    waitIdle();
    chk(nvm_pkg::OFS_RELOAD, 8'h01);
    cmp(bfm.mem[12'h010], 8'h5A);
    cmp(bfm.mem[12'h011], 8'hC3);
    cmp(8'(updCount - c), 8'h01);
    chk(nvm_pkg::OFS_ERROR, 8'h00);
  endtask : tLoad
  task automatic tOverrun();
    for (int i = 0; i < nvm_pkg::NVM_DEPTH; i++) begin
      bfm.mem[nvm_pkg::SEG_BASE + 12'(i)] = nvm_pkg::OP_UPDATE;
    end
    wr(nvm_pkg::OFS_SAVE, 8'h01);
    waitIdle();
    wr(nvm_pkg::OFS_RELOAD, 8'h03);
    waitIdle();
    chk(nvm_pkg::OFS_ERROR, 8'h01);
    chk(nvm_pkg::OFS_STATUS, 8'h00);
  endtask : tOverrun
  task automatic tError();
    bfm.mem[12'hA00] = 8'h85;
    wr(nvm_pkg::OFS_SAVE, 8'h01);
    waitIdle();
    wr(nvm_pkg::OFS_RELOAD, 8'h03);
    waitIdle();
    chk(nvm_pkg::OFS_ERROR, 8'h01);
    chk(nvm_pkg::OFS_STATUS, 8'h00);
  endtask : tError
  initial begin
    repeat (10) @(posedge core_clk);
    #1;
    reset_n = 1'b1;
    tReset();
    tUpdate();
    tSave();
    tLoad();
    tOverrun();
    tError();
    giveVerdict();
  end
endmodule : config_eeprom_control_tb
`default_nettype wire
